// >>> logic/phy_mgmt_defs.vh
`ifndef PHY_MGMT_DEFS_VH
`define PHY_MGMT_DEFS_VH

// ==========================================================
// Register addresses
`define REG_CONTROL 5'h00
`define REG_STATUS 5'h01
`define BCAST_ADDR 5'h00

// ==========================================================
// Control register bit positions
`define CTL_RESET 15
`define CTL_LOOPBACK 14
`define CTL_SPEED 13
`define CTL_AN_EN 12
`define CTL_POWER_DOWN 11
`define CTL_ISOLATE 10
`define CTL_AN_RESTART 9
`define CTL_DUPLEX 8
`define CTL_COLTEST 7

// Control register reset values
`define RST_LOOPBACK 1'h0
`define RST_SPEED 1'h1
`define RST_AN_EN 1'h1
`define RST_POWER_DOWN 1'h0
`define RST_ISOLATE 1'h0
`define RST_DUPLEX 1'h1
`define RST_COLTEST 1'h0

// ==========================================================
// Status register bit positions and fixed content
`define STS_AN_DONE 5
`define STS_REMOTE_FAULT_LATCHED 4
`define STS_AN_ABLE 3
`define STS_LINK 2
`define STS_JABBER 1
`define STS_FIXED 16'h7801

// ==========================================================
// Management frame layout
`define PRE_LEN 6'h20
`define HDR_LAST 4'hC
`define DATA_LAST 4'hF
`define HDR_ST_BIT 12
`define HDR_OP_HI 11
`define HDR_OP_LO 10
`define HDR_PHY_HI 9
`define HDR_PHY_LO 5
`define HDR_REG_HI 4
`define HDR_REG_LO 0
`define OP_READ 2'h2
`define OP_WRITE 2'h1

`endif

// >>> logic/phy_mgmt_control_status_regs.v
`include "phy_mgmt_defs.vh"
`default_nettype none

module phy_mgmt_control_status_regs (
  input wire i_clk_sys,
  input wire i_nrst,
  input wire i_mdc,
  input wire i_mdio_in,
  output reg o_mdio_out,
  output reg o_mdio_oe,
  input wire [4:0] i_phy_addr,
  input wire [3:0] i_txd,
  input wire i_tx_en,
  output reg [3:0] o_rxd,
  output reg o_rx_dv,
  output reg o_col,
  output reg o_mii_oe,
  input wire [3:0] i_line_rxd,
  input wire i_line_rx_dv,
  input wire i_line_col,
  output reg [3:0] o_line_txd,
  output reg o_line_tx_en,
  input wire i_link_ok,
  input wire i_remote_fault,
  input wire i_jabber,
  input wire i_an_done,
  input wire i_an_speed_100,
  input wire i_an_full_duplex,
  input wire i_pcs_bypass,
  output reg o_speed_100,
  output reg o_full_duplex,
  output reg o_autoneg_enable,
  output reg o_autoneg_restart,
  output reg o_power_down,
  output reg o_soft_reset
);

  // ==========================================================
  // Input synchronisers
  localparam SYNC_W = 25;
  localparam [3:0] ST_PRE = 4'h1;
  localparam [3:0] ST_HDR = 4'h2;
  localparam [3:0] ST_TA = 4'h4;
  localparam [3:0] ST_DATA = 4'h8;

  wire [SYNC_W-1:0] async_in;
  reg [SYNC_W-1:0] sync1_q;
  reg [SYNC_W-1:0] sync2_q;

  assign async_in = {i_mdc, i_mdio_in, i_txd, i_tx_en, i_line_rxd, i_line_rx_dv,
    i_line_col, i_link_ok, i_remote_fault, i_jabber, i_an_done, i_an_speed_100,
    i_an_full_duplex, i_pcs_bypass, i_phy_addr};

  // Two flops on every pin input except clock and reset
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= {SYNC_W{1'b0}};
      sync2_q <= {SYNC_W{1'b0}};
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  wire mdc_s = sync2_q[24];
  wire mdio_s = sync2_q[23];
  wire [3:0] txd_s = sync2_q[22:19];
  wire tx_en_s = sync2_q[18];
  wire [3:0] line_rxd_s = sync2_q[17:14];
  wire line_rx_dv_s = sync2_q[13];
  wire line_col_s = sync2_q[12];
  wire link_s = sync2_q[11];
  wire remote_fault_latched_s = sync2_q[10];
  wire jabber_s = sync2_q[9];
  wire an_done_s = sync2_q[8];
  wire an_speed_s = sync2_q[7];
  wire an_dup_s = sync2_q[6];
  wire pcs_bypass_s = sync2_q[5];
  wire [4:0] phy_addr_s = sync2_q[4:0];

  // ==========================================================
  // Control and status storage
  reg loopback_enable_q;
  reg speed_select_q;
  reg autoneg_enable_q;
  reg power_down_q;
  reg isolate_q;
  reg duplex_q;
  reg collision_test_q;
  reg remote_fault_latched_q;
  reg jabber_latched_q;
  reg link_fail_q;
  reg link_prev_q;
  reg powerup_q;

  // Frame engine state
  reg [3:0] state_q;
  reg [5:0] pre_cnt_q;
  reg [3:0] bit_cnt_q;
  reg [11:0] hdr_q;
  reg is_rd_q;
  reg is_wr_q;
  reg [4:0] reg_sel_q;
  reg [15:0] rd_sh_q;
  reg [15:0] wr_sh_q;
  reg mdc_prev_q;
  reg wr_go_q;
  reg rd_clr_q;

  wire mdc_rise = mdc_s & ~mdc_prev_q;
  wire [12:0] hdr_full = {hdr_q, mdio_s};
  wire [4:0] hdr_phy = hdr_full[`HDR_PHY_HI:`HDR_PHY_LO];
  wire [4:0] hdr_reg = hdr_full[`HDR_REG_HI:`HDR_REG_LO];
  wire [1:0] hdr_op = hdr_full[`HDR_OP_HI:`HDR_OP_LO];
  wire hdr_ok = hdr_full[`HDR_ST_BIT] &
    ((hdr_phy == phy_addr_s) | (hdr_phy == `BCAST_ADDR));
  wire wr_ctl = wr_go_q & (reg_sel_q == `REG_CONTROL);
  wire soft_rst = wr_ctl & wr_sh_q[`CTL_RESET];

  // Supported register decode
  function reg_known;
    input [4:0] addr;
    begin
      reg_known = (addr == `REG_CONTROL) | (addr == `REG_STATUS);
    end
  endfunction

  // ==========================================================
  // Register read views
  reg [15:0] ctl_word;
  reg [15:0] sts_word;

  // Control view; reset and restart read zero, reserved bits zero
  always @* begin
    ctl_word = 16'h0000;
    ctl_word[`CTL_LOOPBACK] = loopback_enable_q;
    ctl_word[`CTL_SPEED] = speed_select_q;
    ctl_word[`CTL_AN_EN] = autoneg_enable_q;
    ctl_word[`CTL_POWER_DOWN] = power_down_q;
    ctl_word[`CTL_ISOLATE] = isolate_q;
    ctl_word[`CTL_DUPLEX] = duplex_q;
    ctl_word[`CTL_COLTEST] = collision_test_q;
  end

  // Status view; AN ability bit follows the AN enable bit, other abilities fixed
  always @* begin
    sts_word = `STS_FIXED;
    sts_word[`STS_AN_DONE] = an_done_s & autoneg_enable_q;
    sts_word[`STS_REMOTE_FAULT_LATCHED] = remote_fault_latched_q;
    sts_word[`STS_AN_ABLE] = autoneg_enable_q;
    sts_word[`STS_LINK] = link_s & ~link_fail_q;
    sts_word[`STS_JABBER] = jabber_latched_q;
  end

  // ==========================================================
  // Management frame engine, stepped on each rising MDC edge
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_PRE;
      pre_cnt_q <= 6'h00;
      bit_cnt_q <= 4'h0;
      hdr_q <= 12'h000;
      is_rd_q <= 1'b0;
      is_wr_q <= 1'b0;
      reg_sel_q <= 5'h00;
      rd_sh_q <= 16'h0000;
      wr_sh_q <= 16'h0000;
      mdc_prev_q <= 1'b0;
      wr_go_q <= 1'b0;
      rd_clr_q <= 1'b0;
      o_mdio_out <= 1'b0;
      o_mdio_oe <= 1'b0;
    end else begin
      mdc_prev_q <= mdc_s;
      wr_go_q <= 1'b0;
      rd_clr_q <= 1'b0;
      if (mdc_rise) begin
        case (state_q)
          ST_PRE: begin
            if (mdio_s) begin
              if (pre_cnt_q != `PRE_LEN) begin
                pre_cnt_q <= pre_cnt_q + 6'h01;
              end
            end else begin
              if (pre_cnt_q == `PRE_LEN) begin
                state_q <= ST_HDR;
                bit_cnt_q <= 4'h0;
              end
              pre_cnt_q <= 6'h00;
            end
          end
          ST_HDR: begin
            hdr_q <= hdr_full[11:0];
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == `HDR_LAST) begin
              state_q <= ST_TA;
              bit_cnt_q <= 4'h0;
              reg_sel_q <= hdr_reg;
              // Unknown registers are never answered
              is_rd_q <= hdr_ok & (hdr_op == `OP_READ) & reg_known(hdr_reg);
              is_wr_q <= hdr_ok & (hdr_op == `OP_WRITE) & reg_known(hdr_reg);
            end
          end
          ST_TA: begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'h0) begin
              // Second turnaround bit is driven low by the device
              o_mdio_oe <= is_rd_q;
              o_mdio_out <= 1'b0;
            end else begin
              state_q <= ST_DATA;
              bit_cnt_q <= 4'h0;
              if (is_rd_q) begin
                if (reg_sel_q == `REG_STATUS) begin
                  o_mdio_out <= sts_word[15];
                  rd_sh_q <= {sts_word[14:0], 1'b0};
                  rd_clr_q <= 1'b1;
                end else begin
                  o_mdio_out <= ctl_word[15];
                  rd_sh_q <= {ctl_word[14:0], 1'b0};
                end
              end
            end
          end
          ST_DATA: begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            wr_sh_q <= {wr_sh_q[14:0], mdio_s};
            o_mdio_out <= rd_sh_q[15] & is_rd_q;
            rd_sh_q <= {rd_sh_q[14:0], 1'b0};
            if (bit_cnt_q == `DATA_LAST) begin
              state_q <= ST_PRE;
              pre_cnt_q <= 6'h00;
              o_mdio_oe <= 1'b0;
              o_mdio_out <= 1'b0;
              wr_go_q <= is_wr_q;
              is_rd_q <= 1'b0;
              is_wr_q <= 1'b0;
            end
          end
          default: begin
            state_q <= ST_PRE;
            pre_cnt_q <= 6'h00;
            o_mdio_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Control register writes and self-clearing actions
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      loopback_enable_q <= `RST_LOOPBACK;
      speed_select_q <= `RST_SPEED;
      autoneg_enable_q <= `RST_AN_EN;
      power_down_q <= `RST_POWER_DOWN;
      isolate_q <= `RST_ISOLATE;
      duplex_q <= `RST_DUPLEX;
      collision_test_q <= `RST_COLTEST;
      powerup_q <= 1'b1;
      o_autoneg_restart <= 1'b0;
      o_soft_reset <= 1'b0;
    end else begin
      powerup_q <= 1'b0;
      o_soft_reset <= soft_rst;
      // Negotiation starts after power-up, soft reset or a restart write
      o_autoneg_restart <= powerup_q | soft_rst |
        (wr_ctl & wr_sh_q[`CTL_AN_RESTART]);
      if (soft_rst) begin
        loopback_enable_q <= `RST_LOOPBACK;
        speed_select_q <= `RST_SPEED;
        autoneg_enable_q <= `RST_AN_EN;
        power_down_q <= `RST_POWER_DOWN;
        isolate_q <= `RST_ISOLATE;
        duplex_q <= `RST_DUPLEX;
        collision_test_q <= `RST_COLTEST;
      end else if (wr_ctl) begin
        loopback_enable_q <= wr_sh_q[`CTL_LOOPBACK];
        autoneg_enable_q <= wr_sh_q[`CTL_AN_EN];
        power_down_q <= wr_sh_q[`CTL_POWER_DOWN];
        isolate_q <= wr_sh_q[`CTL_ISOLATE];
        collision_test_q <= wr_sh_q[`CTL_COLTEST];
        if (!autoneg_enable_q) begin
          speed_select_q <= wr_sh_q[`CTL_SPEED];
          duplex_q <= wr_sh_q[`CTL_DUPLEX];
        end
      end
    end
  end

  // ==========================================================
  // Latched status bits; a new event wins over the read clear
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      remote_fault_latched_q <= 1'b0;
      jabber_latched_q <= 1'b0;
      link_fail_q <= 1'b0;
      link_prev_q <= 1'b0;
    end else begin
      link_prev_q <= link_s;
      if (soft_rst) begin
        remote_fault_latched_q <= 1'b0;
        jabber_latched_q <= 1'b0;
        link_fail_q <= 1'b0;
      end else begin
        remote_fault_latched_q <= remote_fault_latched_s |
          (remote_fault_latched_q & ~rd_clr_q);
        jabber_latched_q <= (jabber_s & ~o_speed_100) |
          (jabber_latched_q & ~rd_clr_q);
        link_fail_q <= (link_prev_q & ~link_s) | (link_fail_q & ~rd_clr_q);
      end
    end
  end

  // ==========================================================
  // Operating mode and MII datapath
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_speed_100 <= `RST_SPEED;
      o_full_duplex <= `RST_DUPLEX;
      o_autoneg_enable <= `RST_AN_EN;
      o_power_down <= `RST_POWER_DOWN;
      o_rxd <= 4'h0;
      o_rx_dv <= 1'b0;
      o_col <= 1'b0;
      o_mii_oe <= 1'b0;
      o_line_txd <= 4'h0;
      o_line_tx_en <= 1'b0;
    end else begin
      // Manual bits only steer the mode with negotiation off
      o_speed_100 <= autoneg_enable_q ? an_speed_s : speed_select_q;
      o_full_duplex <= autoneg_enable_q ? an_dup_s : duplex_q;
      o_autoneg_enable <= autoneg_enable_q;
      o_power_down <= power_down_q;
      o_mii_oe <= ~isolate_q;
      // Loopback turns transmit back and silences the line
      if (loopback_enable_q) begin
        o_rxd <= txd_s;
        o_rx_dv <= tx_en_s;
        o_line_txd <= 4'h0;
        o_line_tx_en <= 1'b0;
      end else begin
        o_rxd <= line_rxd_s;
        o_rx_dv <= line_rx_dv_s;
        o_line_txd <= txd_s;
        o_line_tx_en <= tx_en_s;
      end
      if (collision_test_q && !pcs_bypass_s) begin
        o_col <= tx_en_s;
      end else begin
        o_col <= line_col_s & ~loopback_enable_q;
      end
    end
  end

endmodule // phy_mgmt_control_status_regs

`default_nettype wire

// >>> tb/phy_mgmt_chk.sv
`default_nettype none
module phy_mgmt_chk (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_mdc,
  input wire logic i_tx_en,
  input wire logic i_line_col,
  input wire logic o_mdio_out,
  input wire logic o_mdio_oe,
  input wire logic o_col,
  input wire logic o_soft_reset,
  input wire logic o_autoneg_restart,
  input wire logic o_autoneg_enable,
  input wire logic o_power_down
);
  // Read drive span: 17 MDC periods of 20 system cycles each
  localparam int OE_MIN = 330;
  localparam int OE_MAX = 350;
  logic mdc_q;
  logic [7:0] since_q;
  logic [8:0] oe_cnt_q;
  logic [3:0] up_q;
  logic seen_q;
  // ==========================================================
  // Helpers: cycles since MDC rise, drive length, cycles since reset
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      mdc_q <= 1'b0;
      since_q <= 8'hFF;
      oe_cnt_q <= 9'h000;
      up_q <= 4'h0;
      seen_q <= 1'b0;
    end else begin
      mdc_q <= i_mdc;
      if (i_mdc && !mdc_q) since_q <= 8'h00;
      else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
      oe_cnt_q <= o_mdio_oe ? oe_cnt_q + 9'h001 : 9'h000;
      if (up_q != 4'hF) up_q <= up_q + 4'h1;
      if (o_autoneg_restart) seen_q <= 1'b1;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence hold_s; o_mdio_oe [*8]; endsequence
  sequence defaults_s; ##[0:4] (o_autoneg_enable && !o_power_down); endsequence
  sequence restart_s; ##[0:2] o_autoneg_restart; endsequence
  // ==========================================================
  // Checks
  ta_zero_a: assert property ($rose(o_mdio_oe) |-> !o_mdio_out)
    else $error("turnaround bit not low");
  drive_hold_a: assert property ($rose(o_mdio_oe) |-> hold_s)
    else $error("read drive too short");
  oe_length_a: assert property ($fell(o_mdio_oe) |-> oe_cnt_q inside {[OE_MIN:OE_MAX]})
    else $error("read drive length wrong");
  bit_timing_a: assert property ($changed(o_mdio_out) && o_mdio_oe && $past(o_mdio_oe)
    |-> since_q inside {[1:7]})
    else $error("data bit not after MDC rise");
  oe_timing_a: assert property ($rose(o_mdio_oe) |-> since_q inside {[1:7]})
    else $error("drive start not after MDC rise");
  soft_default_a: assert property (o_soft_reset |-> defaults_s)
    else $error("soft reset left modes");
  soft_restart_a: assert property (o_soft_reset |-> restart_s)
    else $error("soft reset without restart");
  restart_single_a: assert property (o_autoneg_restart |=> !o_autoneg_restart)
    else $error("restart pulse too long");
  power_up_a: assert property (up_q == 4'h6 |-> seen_q)
    else $error("no negotiation start");
  col_cause_a: assert property ($rose(o_col) |-> $past(i_tx_en, 2) || $past(i_line_col, 2))
    else $error("collision without cause");
endmodule // phy_mgmt_chk

bind phy_mgmt_control_status_regs phy_mgmt_chk u_chk (
  .i_clk_sys(i_clk_sys),
  .i_nrst(i_nrst),
  .i_mdc(i_mdc),
  .i_tx_en(i_tx_en),
  .i_line_col(i_line_col),
  .o_mdio_out(o_mdio_out),
  .o_mdio_oe(o_mdio_oe),
  .o_col(o_col),
  .o_soft_reset(o_soft_reset),
  .o_autoneg_restart(o_autoneg_restart),
  .o_autoneg_enable(o_autoneg_enable),
  .o_power_down(o_power_down)
);
`default_nettype wire

// >>> tb/mgmt_station.sv
`include "phy_mgmt_defs.vh"
`default_nettype none
module mgmt_station (
  output logic o_mdc,
  output logic o_mdio_out,
  output logic o_mdio_oe,
  input wire logic i_mdio,
  input wire logic i_phy_oe,
  output logic o_done,
  output logic [16:0] o_result
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Idle: MDC parked low, data line released
  initial begin
    o_mdc = 1'b0;
    o_mdio_out = 1'b0;
    o_mdio_oe = 1'b0;
    o_done = 1'b0;
    o_result = 17'h00000;
  end
  // One 80 ns MDC period: drive while low, sample just before the rise
  task automatic tick(input logic oe, input logic val, output logic smp);
    o_mdio_oe = oe;
    o_mdio_out = val;
    #40;
    smp = i_mdio;
    o_mdc = 1'b1;
    #40;
    o_mdc = 1'b0;
  endtask
  // Whole frame; a read releases the line from turnaround on
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
    input logic [15:0] wd);
    logic [13:0] hdr;
    logic rdop;
    logic s;
    logic seen;
    logic [15:0] rv;
    int i;
    hdr = {2'h1, op, phy, ra};
    rdop = (op == `OP_READ);
    seen = 1'b0;
    rv = 16'h0000;
    for (i = 0; i < 32; i++) tick(1'b1, 1'b1, s);
    for (i = 13; i >= 0; i--) tick(1'b1, hdr[i], s);
    tick(!rdop, 1'b1, s);
    tick(!rdop, 1'b0, s);
    for (i = 15; i >= 0; i--) begin
      tick(!rdop, wd[i], s);
      rv = {rv[14:0], s};
      seen = seen | i_phy_oe;
    end
    o_mdio_oe = 1'b0;
    if (rdop) begin
      o_result = {seen, rv};
      o_done = 1'b1;
      #1;
      o_done = 1'b0;
    end
  endtask
endmodule // mgmt_station
`default_nettype wire

// >>> tb/phy_mgmt_control_status_regs_test.sv
`include "phy_mgmt_defs.vh"
`default_nettype none
`define CHK(nm, ex, got) begin \
  compares++; \
  if ((got) !== (ex)) begin \
    err_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module phy_mgmt_control_status_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic mdc, st_out, st_oe, dut_out, dut_oe, st_done;
  wire logic mdio;
  logic [16:0] st_res;
  logic [3:0] txd = 4'h0, rxd, line_rxd = 4'h0, line_txd;
  logic tx_en = 1'b0, rx_dv, col, mii_oe, line_dv = 1'b0, line_tx_en;
  logic link = 1'b0, remote_fault_latched = 1'b0, jabber_latched = 1'b0, an_done = 1'b0, bypass = 1'b0;
  logic spd, dup, an_en, an_rst, pwr, srst;
  logic [16:0] exp_q[$];
  logic [15:0] rng = 16'h000F;
  int err_count = 0, compares = 0, restarts = 0, n, i;
  // ==========================================================
  // Clock, pulled-up data line, restart counter
  always #2 clk = ~clk;
  assign mdio = dut_oe ? dut_out : (st_oe ? st_out : 1'b1);
  always @(posedge clk) if (an_rst === 1'b1) restarts <= restarts + 1;
  phy_mgmt_control_status_regs dut (.i_clk_sys(clk), .i_nrst(nrst), .i_mdc(mdc),
    .i_mdio_in(mdio), .o_mdio_out(dut_out), .o_mdio_oe(dut_oe), .i_phy_addr(5'h05),
    .i_txd(txd), .i_tx_en(tx_en), .o_rxd(rxd), .o_rx_dv(rx_dv), .o_col(col),
    .o_mii_oe(mii_oe), .i_line_rxd(line_rxd), .i_line_rx_dv(line_dv), .i_line_col(1'b0),
    .o_line_txd(line_txd), .o_line_tx_en(line_tx_en), .i_link_ok(link),
    .i_remote_fault(remote_fault_latched), .i_jabber(jabber_latched), .i_an_done(an_done), .i_an_speed_100(1'b1),
    .i_an_full_duplex(1'b1), .i_pcs_bypass(bypass), .o_speed_100(spd),
    .o_full_duplex(dup), .o_autoneg_enable(an_en), .o_autoneg_restart(an_rst),
    .o_power_down(pwr), .o_soft_reset(srst));
  mgmt_station mgmt (.o_mdc(mdc), .o_mdio_out(st_out), .o_mdio_oe(st_oe), .i_mdio(mdio),
    .i_phy_oe(dut_oe), .o_done(st_done), .o_result(st_res));
  function automatic logic [15:0] xs(input logic [15:0] v);
    logic [15:0] t;
    t = v ^ (v << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction
  // Frames start on a falling system edge so MDC never moves as it is sampled
  task automatic wr(input logic [15:0] d);
    @(negedge clk);
    mgmt.frame(`OP_WRITE, 5'h05, `REG_CONTROL, d);
  endtask
  task automatic rd(input logic [4:0] phy, input logic [4:0] ra, input logic [16:0] e);
    exp_q.push_back(e);
    @(negedge clk);
    mgmt.frame(`OP_READ, phy, ra, 16'h0000);
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Read answers against the oldest noted expectation
  always @(posedge st_done) begin
    `CHK("mdio read", exp_q[0], st_res)
    void'(exp_q.pop_front());
  end
  // Watchdog: frames need about 30k cycles, allow 100k
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    rd(5'h00, `REG_CONTROL, {1'b1, 16'h3100});
    rd(5'h05, `REG_STATUS, {1'b1, 16'h7809});
    wr(16'h107F);
    rd(5'h05, `REG_CONTROL, {1'b1, 16'h3100});
    wr(16'h0000);
    rd(5'h05, `REG_CONTROL, {1'b1, 16'h2100});
    wr(16'h0000);
    rd(5'h05, `REG_CONTROL, {1'b1, 16'h0000});
    `CHK("speed", 1'b0, spd)
    `CHK("duplex", 1'b0, dup)
    `CHK("an_en", 1'b0, an_en)
    rd(5'h05, `REG_STATUS, {1'b1, 16'h7801});
    jabber_latched <= 1'b1;
    remote_fault_latched <= 1'b1;
    repeat (8) @(posedge clk);
    jabber_latched <= 1'b0;
    remote_fault_latched <= 1'b0;
    link <= 1'b1;
    repeat (8) @(posedge clk);
    rd(5'h05, `REG_STATUS, {1'b1, 16'h7817});
    rd(5'h05, `REG_STATUS, {1'b1, 16'h7805});
    link <= 1'b0;
    repeat (8) @(posedge clk);
    link <= 1'b1;
    repeat (8) @(posedge clk);
    rd(5'h05, `REG_STATUS, {1'b1, 16'h7801});
    rd(5'h05, `REG_STATUS, {1'b1, 16'h7805});
    wr(16'h4000);
    for (i = 0; i < 8; i++) begin
      rng = xs(rng);
      txd <= rng[3:0];
      tx_en <= rng[4];
      line_rxd <= ~rng[3:0];
      line_dv <= ~rng[4];
      repeat (6) @(posedge clk);
      `CHK("rxd", rng[3:0], rxd)
      `CHK("rx_dv", rng[4], rx_dv)
      `CHK("line tx", 4'h0, line_txd | line_tx_en)
    end
    wr(16'h0080);
    for (i = 0; i < 4; i++) begin
      tx_en <= i[0];
      bypass <= i[1];
      repeat (6) @(posedge clk);
      `CHK("col", i[0] & ~i[1], col)
    end
    tx_en <= 1'b0;
    wr(16'h0C00);
    `CHK("mii_oe", 1'b0, mii_oe)
    `CHK("power", 1'b1, pwr)
    rd(5'h05, `REG_CONTROL, {1'b1, 16'h0C00});
    rd(5'h05, 5'h02, {1'b0, 16'hFFFF});
    rd(5'h03, `REG_CONTROL, {1'b0, 16'hFFFF});
    wr(16'h8000);
    an_done <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("power", 1'b0, pwr)
    `CHK("mii_oe", 1'b1, mii_oe)
    rd(5'h05, `REG_STATUS, {1'b1, 16'h782D});
    n = restarts;
    wr(16'h1200);
    `CHK("restarts", n + 1, restarts)
    rd(5'h05, `REG_CONTROL, {1'b1, 16'h3100});
    `CHK("an_en", 1'b1, an_en)
    `CHK("pending", 0, exp_q.size())
    tally_and_finish();
  end
endmodule // phy_mgmt_control_status_regs_test
`default_nettype wire
